// ===== logic/kpi_pkg.sv
// Package with register map, field positions and carrier types for the key pin interrupt block
package kpi_pkg;

  // ==========================================================
  // Bus geometry
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int REG_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [AXI_AW-1:0] OFS_STATUS_CONTROL = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_INPUT_ENABLE = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_POLARITY_SELECT = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_PORT_PULL_ENABLE = 8'h0C;
  localparam logic [AXI_AW-1:0] OFS_EVT_STATUS = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_EVT_CLEAR = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_EVT_ENABLE = 8'h18;

  // ==========================================================
  // Status and control field positions
  localparam int BIT_MODE_SEL = 0;
  localparam int BIT_IRQ_ENABLE = 1;
  localparam int BIT_FLAG_ACK = 2;
  localparam int BIT_DETECT_FLAG = 3;

  // Event status positions
  localparam int EVT_W = 3;
  localparam int EVT_EDGE = 0;
  localparam int EVT_LEVEL = 1;
  localparam int EVT_ACK_REFUSED = 2;

  // ==========================================================
  // Reset values
  localparam logic [REG_W-1:0] RST_REG = 8'h00;
  localparam logic [EVT_W-1:0] RST_EVT = 3'h0;

  typedef struct packed {
    logic irqEnable;
    logic detectModeSel;
  } kpi_ctrl_type;

  typedef struct packed {
    logic [REG_W-1:0] inputEnable;
    logic [REG_W-1:0] polaritySelect;
    logic [REG_W-1:0] portPullEnable;
  } kpi_pin_cfg_type;

endpackage

// ===== logic/kpi_sync.sv
// Two-stage synchroniser for a group of level inputs
`timescale 1ns/1ps
module kpi_sync #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  // ==========================================================
  // First stage feeds only the second stage
  logic [W-1:0] stage1_ff;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_ff <= '0;
      syncOut <= '0;
    end else begin
      stage1_ff <= asyncIn;
      syncOut <= stage1_ff;
    end
  end

endmodule

// ===== logic/kpi_keyboard_pin_interrupt.sv
// Key pin interrupt detector with AXI4-Lite register slave
//
// Behaviour
// - Bits 7:4 of status_control always read as zero.
// - Bit 3 holds the read-only detect flag, set on detection and unchanged by writes.
// - Writing one to bit 2 requests a flag clear, and bit 2 always reads zero.
// - Bit 1 is the interrupt enable; the CPU request is high one cycle after flag and enable are both set.
// - Bit 0 selects edge-only detection at zero and edge-plus-level detection at one.
// - Each input takes part in detection only while its input_enable bit is one.
// - Polarity zero means falling edge and low level, one means rising edge and high level.
// - Falling polarity detects an enabled input sampled high then low in the next cycle.
// - Rising polarity detects an enabled input sampled low then high in the next cycle.
// - A new edge counts only after all enabled inputs were deasserted, first edge too.
// - In edge-only mode a valid edge sets the flag and an acknowledge write clears it.
// - In edge-and-level mode a valid edge or an asserted level sets the flag.
// - In edge-and-level mode acknowledge clears the flag only when all enabled inputs are idle.
// - An enabled pull resistor is a pullup for polarity zero and a pulldown for one.
// - All KEY_W inputs (one to eight, eight by default) feed the one shared detect flag.
`timescale 1ns/1ps
module kpi_keyboard_pin_interrupt
  import kpi_pkg::*;
#(
  parameter int KEY_W = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [KEY_W-1:0] keyInput,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic cpuIrq,
  output logic evtIrq,
  output logic [KEY_W-1:0] pullUpEn,
  output logic [KEY_W-1:0] pullDownEn
);

  // Only one byte lane carries key bits, so wider groups cannot be served
  if (KEY_W < 1 || KEY_W > REG_W) begin : g_bad_key_w
    $error("KEY_W must be 1 to 8");
  end

  // Set wins over clear for every sticky bit
  function automatic logic [REG_W-1:0] sticky(input logic [REG_W-1:0] cur,
      input logic [REG_W-1:0] setV, input logic [REG_W-1:0] clrV);
    sticky = (cur & ~clrV) | setV;
  endfunction

  // ==========================================================
  // Register state
  kpi_ctrl_type ctrl_ff;
  kpi_pin_cfg_type pinCfg_ff;
  logic detectFlag_ff;
  logic [EVT_W-1:0] evtStatus_ff;
  logic [EVT_W-1:0] evtEnable_ff;

  // ==========================================================
  // Bus slave state
  logic awHeld_ff;
  logic [AXI_AW-1:0] awAddr_ff;
  logic wHeld_ff;
  logic [AXI_DW-1:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic [AXI_AW-1:0] rdAddr_ff;
  logic doWrite;
  logic wrLane0;

  assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
  assign wrLane0 = doWrite && wStrb_ff[0];

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    mapped = (a == OFS_STATUS_CONTROL) || (a == OFS_INPUT_ENABLE) ||
             (a == OFS_POLARITY_SELECT) || (a == OFS_PORT_PULL_ENABLE) ||
             (a == OFS_EVT_STATUS) || (a == OFS_EVT_CLEAR) ||
             (a == OFS_EVT_ENABLE);
  endfunction

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awHeld_ff <= 1'b1;
      awAddr_ff <= s_axi_awaddr;
    end else begin
      if (doWrite) begin
        awHeld_ff <= 1'b0;
      end
      if (!awHeld_ff && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_wready <= 1'b0;
      wHeld_ff <= 1'b0;
      wData_ff <= '0;
      wStrb_ff <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wHeld_ff <= 1'b1;
      wData_ff <= s_axi_wdata;
      wStrb_ff <= s_axi_wstrb;
    end else begin
      if (doWrite) begin
        wHeld_ff <= 1'b0;
      end
      if (!wHeld_ff && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Input sampling and detection
  logic [KEY_W-1:0] keySync;
  logic [KEY_W-1:0] asserted;
  logic [KEY_W-1:0] prevAsserted_ff;
  logic [KEY_W-1:0] enMask;
  logic anyAsserted;
  logic armed_ff;
  logic edgeHit;
  logic levelHit;
  logic flagSet;
  logic ackWrite;
  logic ackRefused;

  kpi_sync #(
    .W(KEY_W)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .asyncIn(keyInput),
    .syncOut(keySync)
  );

  assign enMask = pinCfg_ff.inputEnable[KEY_W-1:0];
  // Asserted level follows the per-input polarity
  assign asserted = enMask & (keySync ~^ pinCfg_ff.polaritySelect[KEY_W-1:0]);
  assign anyAsserted = |asserted;
  // Previous sample deasserted, current asserted: falling or rising edge by polarity
  assign edgeHit = armed_ff && |(asserted & ~prevAsserted_ff);
  assign levelHit = ctrl_ff.detectModeSel && anyAsserted;
  assign flagSet = edgeHit || levelHit;
  assign ackWrite = wrLane0 && (awAddr_ff == OFS_STATUS_CONTROL) &&
                    wData_ff[BIT_FLAG_ACK];
  assign ackRefused = ackWrite && ctrl_ff.detectModeSel && anyAsserted;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prevAsserted_ff <= '0;
    end else begin
      // Disabled inputs sample as deasserted, so enabling an input while asserted
      // counts as an edge only once the block is armed
      prevAsserted_ff <= asserted;
    end
  end

  // Armed only after every enabled input sat idle; starts disarmed
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      armed_ff <= 1'b0;
    end else if (!anyAsserted) begin
      armed_ff <= 1'b1;
    end else if (edgeHit) begin
      armed_ff <= 1'b0;
    end
  end

  // Detection beats a simultaneous acknowledge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      detectFlag_ff <= 1'b0;
    end else if (flagSet) begin
      detectFlag_ff <= 1'b1;
    end else if (ackWrite && !ackRefused) begin
      detectFlag_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cpuIrq <= 1'b0;
    end else begin
      cpuIrq <= detectFlag_ff && ctrl_ff.irqEnable;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= '0;
      pinCfg_ff <= {RST_REG, RST_REG, RST_REG};
    end else if (wrLane0) begin
      unique case (awAddr_ff)
        OFS_STATUS_CONTROL: begin
          ctrl_ff.irqEnable <= wData_ff[BIT_IRQ_ENABLE];
          ctrl_ff.detectModeSel <= wData_ff[BIT_MODE_SEL];
        end
        OFS_INPUT_ENABLE: pinCfg_ff.inputEnable <= wData_ff[REG_W-1:0];
        OFS_POLARITY_SELECT: pinCfg_ff.polaritySelect <= wData_ff[REG_W-1:0];
        OFS_PORT_PULL_ENABLE: pinCfg_ff.portPullEnable <= wData_ff[REG_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pullUpEn <= '0;
      pullDownEn <= '0;
    end else begin
      pullUpEn <= pinCfg_ff.portPullEnable[KEY_W-1:0] &
                  ~pinCfg_ff.polaritySelect[KEY_W-1:0];
      pullDownEn <= pinCfg_ff.portPullEnable[KEY_W-1:0] &
                    pinCfg_ff.polaritySelect[KEY_W-1:0];
    end
  end

  // ==========================================================
  // Event status, clear and enable
  logic [REG_W-1:0] evtSet;
  logic [REG_W-1:0] evtClr;
  logic [REG_W-1:0] evtNext;

  always_comb begin
    evtSet = '0;
    evtSet[EVT_EDGE] = edgeHit;
    evtSet[EVT_LEVEL] = levelHit;
    evtSet[EVT_ACK_REFUSED] = ackRefused;
    evtClr = (wrLane0 && awAddr_ff == OFS_EVT_CLEAR) ? wData_ff[REG_W-1:0] : RST_REG;
    evtNext = sticky({{(REG_W-EVT_W){1'b0}}, evtStatus_ff}, evtSet, evtClr);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      evtStatus_ff <= RST_EVT;
      evtEnable_ff <= RST_EVT;
      evtIrq <= 1'b0;
    end else begin
      evtStatus_ff <= evtNext[EVT_W-1:0];
      if (wrLane0 && awAddr_ff == OFS_EVT_ENABLE) begin
        evtEnable_ff <= wData_ff[EVT_W-1:0];
      end
      evtIrq <= |(evtStatus_ff & evtEnable_ff);
    end
  end

  // ==========================================================
  // Read channel
  logic [REG_W-1:0] rdByte;

  always_comb begin
    rdByte = '0;
    unique case (s_axi_araddr)
      OFS_STATUS_CONTROL: begin
        rdByte[BIT_DETECT_FLAG] = detectFlag_ff;
        rdByte[BIT_IRQ_ENABLE] = ctrl_ff.irqEnable;
        rdByte[BIT_MODE_SEL] = ctrl_ff.detectModeSel;
      end
      OFS_INPUT_ENABLE: rdByte = pinCfg_ff.inputEnable;
      OFS_POLARITY_SELECT: rdByte = pinCfg_ff.polaritySelect;
      OFS_PORT_PULL_ENABLE: rdByte = pinCfg_ff.portPullEnable;
      OFS_EVT_STATUS: rdByte[EVT_W-1:0] = evtStatus_ff;
      OFS_EVT_ENABLE: rdByte[EVT_W-1:0] = evtEnable_ff;
      default: rdByte = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      rdAddr_ff <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {{(AXI_DW-REG_W){1'b0}}, rdByte};
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdAddr_ff <= s_axi_araddr;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_upper_zero;
    s_axi_rvalid && rdAddr_ff == OFS_STATUS_CONTROL |-> s_axi_rdata[7:4] == 4'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits nonzero");

  property p_flag_cause;
    $rose(detectFlag_ff) |-> $past(flagSet);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag set without cause");

  property p_ack_reads_zero;
    s_axi_rvalid && rdAddr_ff == OFS_STATUS_CONTROL |-> !s_axi_rdata[BIT_FLAG_ACK];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read one");

  property p_irq;
    detectFlag_ff && ctrl_ff.irqEnable |=> cpuIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("cpu irq missing");

  property p_disabled_quiet;
    enMask == '0 && !detectFlag_ff |=> !detectFlag_ff;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled input set flag");

  property p_edge_sets;
    armed_ff && |(asserted & ~prevAsserted_ff) |=> detectFlag_ff && !armed_ff;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge missed");

  property p_rearm;
    !armed_ff && anyAsserted |=> !armed_ff;
  endproperty
  a_rearm: assert property (p_rearm) else $error("edge while disarmed");

  property p_edge_clear;
    ackWrite && !ctrl_ff.detectModeSel && !flagSet |=> !detectFlag_ff;
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("ack did not clear");

  property p_level_sets;
    ctrl_ff.detectModeSel && anyAsserted |=> detectFlag_ff;
  endproperty
  a_level_sets: assert property (p_level_sets) else $error("level not held");

  property p_level_refuse;
    ackWrite && ctrl_ff.detectModeSel && anyAsserted |=>
      detectFlag_ff && evtStatus_ff[EVT_ACK_REFUSED];
  endproperty
  a_level_refuse: assert property (p_level_refuse)
    else $error("ack cleared while asserted");

  property p_pull;
    ##1 pullUpEn == $past(pinCfg_ff.portPullEnable[KEY_W-1:0] &
                          ~pinCfg_ff.polaritySelect[KEY_W-1:0]);
  endproperty
  a_pull: assert property (p_pull) else $error("pull direction wrong");

  c_edge_irq: cover property (edgeHit ##[1:3] cpuIrq);
  c_refused: cover property (ackRefused);
  c_wr_rd: cover property (doWrite ##[1:20] (s_axi_arvalid && s_axi_arready));

endmodule

// ===== dv/kpi_key_model.sv
// Behavioural model of the key switches and the pull resistors behind the key inputs
`timescale 1ns/1ps
module kpi_key_model (
  input wire logic mclk,
  input wire logic [7:0] drvEn,
  input wire logic [7:0] drvVal,
  input wire logic [7:0] pullUpEn,
  input wire logic [7:0] pullDownEn,
  output logic [7:0] keyLine
);
  // ==========================================================
  // Line levels
  logic [7:0] lastVal = 8'h00;

  always @(posedge mclk) begin
    lastVal <= (drvEn & drvVal) | (~drvEn & lastVal);
  end

  // A released line without a pull floats; showing the inverse of the last level
  // keeps a lucky settle from hiding a missing pull
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drvEn[i]) begin
        keyLine[i] = drvVal[i];
      end else if (pullUpEn[i]) begin
        keyLine[i] = 1'h1;
      end else if (pullDownEn[i]) begin
        keyLine[i] = 1'h0;
      end else begin
        keyLine[i] = ~lastVal[i];
      end
    end
  end
endmodule

// ===== dv/keyboard_pin_interrupt_bench.sv
// Self-checking bench for the key pin interrupt block
`timescale 1ns/1ps
module keyboard_pin_interrupt_bench;
  import kpi_pkg::*;
  // Keys 0..3 active high, keys 4..7 active low
  localparam logic [7:0] POL = 8'h0F;
  logic mclk, rst_b, awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady, cpuIrq, evtIrq;
  logic [7:0] awAddr, arAddr, keyLine, drvEn, drvVal, pullUp, pullDown;
  logic [31:0] wData, rData;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp;
  int errors, nTests, cycles;

  // ==========================================================
  // Clock, watchdog, design and key model
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      end_sim();
    end
  end

  kpi_keyboard_pin_interrupt DUT (.mclk(mclk), .rst_b(rst_b), .keyInput(keyLine),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .cpuIrq(cpuIrq), .evtIrq(evtIrq), .pullUpEn(pullUp), .pullDownEn(pullDown));

  kpi_key_model keys_i (.mclk(mclk), .drvEn(drvEn), .drvVal(drvVal), .pullUpEn(pullUp),
    .pullDownEn(pullDown), .keyLine(keyLine));

  // ==========================================================
  // Shared tasks
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // bready and rready stay high, so every response is taken when first offered
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF,
      input logic [1:0] er = RESP_OKAY);
    logic a1, w1, b1;
    a1 = 1'h0;
    w1 = 1'h0;
    b1 = 1'h0;
    awAddr <= a;
    wData <= {24'h0, d};
    wStrb <= s;
    awValid <= 1'h1;
    wValid <= 1'h1;
    while (!b1) begin
      @(posedge mclk);
      if (!a1 && awReady === 1'h1) begin
        a1 = 1'h1;
        awValid <= 1'h0;
      end
      if (!w1 && wReady === 1'h1) begin
        w1 = 1'h1;
        wValid <= 1'h0;
      end
      if (bValid === 1'h1) begin
        b1 = 1'h1;
        chk("bresp", {30'h0, er}, {30'h0, bResp});
      end
    end
    chk("aw and w before b", 32'h3, {30'h0, a1, w1});
  endtask

  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e,
      input logic [1:0] er = RESP_OKAY);
    logic g, t;
    g = 1'h0;
    t = 1'h0;
    arAddr <= a;
    arValid <= 1'h1;
    while (!g) begin
      @(posedge mclk);
      if (!t && arReady === 1'h1) begin
        t = 1'h1;
        arValid <= 1'h0;
      end
      if (rValid === 1'h1) begin
        g = 1'h1;
        chk(n, {24'h0, e}, rData);
        chk("rresp", {30'h0, er}, {30'h0, rResp});
      end
    end
    chk("ar before r", 32'h1, {31'h0, t});
  endtask

  task automatic keys(input logic [7:0] m);
    drvEn <= m;
    drvVal <= POL;
  endtask

  task automatic bit_chk(input string n, input logic e, input logic got);
    chk(n, {31'h0, e}, {31'h0, got});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] ofs [6] = '{OFS_STATUS_CONTROL, OFS_INPUT_ENABLE, OFS_POLARITY_SELECT,
      OFS_PORT_PULL_ENABLE, OFS_EVT_STATUS, OFS_EVT_ENABLE};
    foreach (ofs[i]) rc("reset value", ofs[i], RST_REG);
    rc("unmapped", 8'h40, 8'h00, RESP_SLVERR);
    bit_chk("cpuIrq", 1'h0, cpuIrq);
  endtask

  task automatic t_init();
    wr(OFS_STATUS_CONTROL, 8'h00);
    wr(OFS_POLARITY_SELECT, POL);
    wr(OFS_PORT_PULL_ENABLE, 8'hFF);
    wr(OFS_INPUT_ENABLE, 8'hFF);
    wr(OFS_STATUS_CONTROL, 8'h04);
    wr(OFS_STATUS_CONTROL, 8'h02);
    wr(OFS_EVT_ENABLE, 8'h07);
    chk("pullUpEn", {24'h0, ~POL}, {24'h0, pullUp});
    chk("pullDownEn", {24'h0, POL}, {24'h0, pullDown});
    rc("sc after init", OFS_STATUS_CONTROL, 8'h02);
  endtask

  task automatic t_edges();
    for (int i = 0; i < 8; i++) begin
      keys(8'h01 << i);
      idle(6);
      rc("flag set", OFS_STATUS_CONTROL, 8'h0A);
      bit_chk("cpuIrq on", 1'h1, cpuIrq);
      if (i == 0) begin
        wr(OFS_STATUS_CONTROL, 8'h02);
        rc("flag kept", OFS_STATUS_CONTROL, 8'h0A);
      end
      keys(8'h00);
      idle(4);
      wr(OFS_STATUS_CONTROL, 8'h06);
      rc("flag cleared", OFS_STATUS_CONTROL, 8'h02);
      bit_chk("cpuIrq off", 1'h0, cpuIrq);
    end
  endtask

  task automatic t_rearm();
    keys(8'h01);
    idle(6);
    wr(OFS_STATUS_CONTROL, 8'h06);
    keys(8'h03);
    idle(6);
    rc("edge while held", OFS_STATUS_CONTROL, 8'h02);
    keys(8'h00);
    idle(6);
    keys(8'h02);
    idle(6);
    rc("edge after idle", OFS_STATUS_CONTROL, 8'h0A);
    keys(8'h00);
    idle(4);
    wr(OFS_STATUS_CONTROL, 8'h06);
    wr(OFS_INPUT_ENABLE, 8'hFE);
    keys(8'h01);
    idle(6);
    rc("disabled key", OFS_STATUS_CONTROL, 8'h02);
    keys(8'h00);
    idle(4);
    wr(OFS_INPUT_ENABLE, 8'hFF);
  endtask

  task automatic t_level();
    keys(8'h04);
    idle(6);
    wr(OFS_STATUS_CONTROL, 8'h06);
    rc("edge mode held", OFS_STATUS_CONTROL, 8'h02);
    wr(OFS_STATUS_CONTROL, 8'h03);
    idle(6);
    rc("level sets", OFS_STATUS_CONTROL, 8'h0B);
    wr(OFS_STATUS_CONTROL, 8'h07);
    rc("ack refused", OFS_STATUS_CONTROL, 8'h0B);
    rc("event status", OFS_EVT_STATUS, 8'h07);
    bit_chk("evtIrq on", 1'h1, evtIrq);
    wr(OFS_EVT_ENABLE, 8'h00);
    idle(2);
    bit_chk("evtIrq masked", 1'h0, evtIrq);
    keys(8'h00);
    idle(4);
    wr(OFS_STATUS_CONTROL, 8'h07);
    rc("ack idle", OFS_STATUS_CONTROL, 8'h03);
    wr(OFS_EVT_ENABLE, 8'h07);
    wr(OFS_EVT_CLEAR, 8'h07);
    idle(2);
    rc("event cleared", OFS_EVT_STATUS, 8'h00);
    bit_chk("evtIrq cleared", 1'h0, evtIrq);
  endtask

  task automatic t_fields();
    wr(OFS_STATUS_CONTROL, 8'hF8);
    rc("upper and flag", OFS_STATUS_CONTROL, 8'h00);
    wr(OFS_INPUT_ENABLE, 8'h00, 4'hE);
    rc("lane 0 strobe off", OFS_INPUT_ENABLE, 8'hFF);
    wr(8'h40, 8'h55, 4'hF, RESP_SLVERR);
    rst_b <= 1'h0;
    idle(3);
    rst_b <= 1'h1;
    idle(1);
    rc("second reset", OFS_POLARITY_SELECT, 8'h00);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {awValid, wValid, arValid, rst_b} = 4'h0;
    {bReady, rReady} = 2'h3;
    {awAddr, arAddr, drvEn, drvVal} = 32'h0;
    wData = 32'h0;
    wStrb = 4'h0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'h1;
    idle(1);
    t_reset();
    t_init();
    t_edges();
    t_rearm();
    t_level();
    t_fields();
    end_sim();
  end
endmodule
